// ### atc_regs.svh
// Register indices, codes, limits and reset values of the acquisition control.
// Assumes APB byte address = register index * 4.
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

`define ATC_IDX_CMD 16'h0000
`define ATC_IDX_STATE 16'h000a
`define ATC_IDX_LEN 16'h2710
`define ATC_IDX_POST 16'h2774
`define ATC_IDX_CHAN 16'h3000
`define ATC_IDX_SETTLE 16'h3001
`define ATC_IDX_DIV 16'h3002
`define ATC_IDX_IRQ_STS 16'h3003
`define ATC_IDX_IRQ_MASK 16'h3004

`define ATC_LAUNCH_CODE 32'h0000_000a
`define ATC_HALT_CODE 32'h0000_0014
`define ATC_ARMED_WAIT 32'h0000_0000
`define ATC_TRIG_SEEN 32'h0000_000a
`define ATC_ACQ_DONE 32'h0000_0014

`define ATC_STEP_ONE 32'h0000_0020
`define ATC_STEP_TWO 32'h0000_0010
`define ATC_MASK_ONE 32'hffff_ffe0
`define ATC_MASK_TWO 32'hffff_fff0
`define ATC_POST_MAX_ONE 32'h0800_0000
`define ATC_POST_MAX_TWO 32'h0400_0000
`define ATC_MEM_SAMPLES 32'h0200_0000

`define ATC_LEN_RST 32'h0000_1000
`define ATC_POST_RST 32'h0000_0800
`define ATC_SETTLE_RST 32'h0000_0000
`define ATC_DIV_RST 16'h0000

`define ATC_IRQ_DONE 0
`define ATC_IRQ_TRIG 1

`endif

// ### atc_pkg.sv
// Types of the acquisition control: sequencer states and the state record.
// Assumes atc_regs.svh for all numeric constants.
package atc_pkg;

    typedef enum logic [2:0] {
        ATC_IDLE, ATC_SETTLE, ATC_PREFILL, ATC_ARMED, ATC_TRIG
    } atc_state_t;

    typedef struct packed {
        atc_state_t st;
        logic [31:0] cmd;
        logic [31:0] len;
        logic [31:0] post;
        logic two_ch;
        logic [31:0] settle;
        logic [15:0] div;
        logic [1:0] irq_sts;
        logic [1:0] irq_mask;
        logic [31:0] run_len;
        logic [31:0] run_post;
        logic [15:0] div_cnt;
        logic [31:0] cnt;
        logic [31:0] waddr;
        logic trig_m;
        logic trig_s;
        logic trig_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic mem_we;
        logic [31:0] mem_addr;
        logic active;
    } atc_s_t;

endpackage

// ### atc_trigger_control.sv
// Acquisition control for standard-mode transient recording, APB slave.
// Assumes one 200 MHz clock, a trigger pin from outside the clock domain,
// and sample memory that accepts mem_addr on each mem_we pulse.
// Contract
// - Total record length per channel is a host read/write register.
// - After-trigger sample count is a host read/write register.
// - Pre-trigger depth is record length minus after-trigger count.
// - Record length limited to half memory with two channels, all with one.
// - After-trigger count at most 128M samples one channel, 64M two.
// - Both counts are multiples of 32 (one channel) or 16 (two), minimum one step.
// - Launch code in command register latches setup and starts acquisition.
// - Halt code ends any running acquisition immediately.
// - Wait programmed settling interval after launch before recording.
// - Status shows armed-and-waiting from launch until trigger.
// - Status shows triggered until after-trigger samples are complete.
// - Status shows stopped after automatic end or halt.
// - Status register is read-only and readable any time.
// - After launch, samples are stored without host help until stop.
// - Record region is a ring buffer until trigger plus after-trigger count.
// - Trigger detection stays disarmed until pre-trigger region is filled.
`include "atc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module atc_trigger_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_in,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic acq_active,
    output logic irq
);

    atc_pkg::atc_s_t s;
    atc_pkg::atc_s_t next_s;

    logic setup_ph;
    logic wr_ph;
    logic [15:0] idx;
    logic tick;
    logic trig_rise;
    logic [31:0] rd_val;
    logic rd_err;
    logic [31:0] state_code;
    logic [1:0] events;
    logic [31:0] len_max;
    logic [31:0] post_max;

    // Snap a count onto the step grid and clamp it to [step, max]
    function automatic logic [31:0] fit(
        input logic [31:0] v,
        input logic [31:0] mx,
        input logic two
    );
        logic [31:0] st;
        logic [31:0] m;
        logic [31:0] r;
        st = two ? `ATC_STEP_TWO : `ATC_STEP_ONE;
        m = two ? `ATC_MASK_TWO : `ATC_MASK_ONE;
        r = v & m;
        if (r < st) begin
            r = st;
        end
        if (r > mx) begin
            r = mx & m;
        end
        return r;
    endfunction

    assign setup_ph = psel && !penable;
    assign wr_ph = psel && penable && pwrite && s.pready;
    assign idx = paddr[17:2];

    assign len_max = s.two_ch ? (`ATC_MEM_SAMPLES >> 1) : `ATC_MEM_SAMPLES;
    assign post_max = s.two_ch ? `ATC_POST_MAX_TWO : `ATC_POST_MAX_ONE;

    assign tick = (s.st != atc_pkg::ATC_IDLE) && (s.st != atc_pkg::ATC_SETTLE)
        && (s.div_cnt == 16'h0000);
    assign trig_rise = s.trig_s && !s.trig_d;

    // Armed code covers settle and prefill too
    always_comb begin
        case (s.st)
            atc_pkg::ATC_IDLE: begin
                state_code = `ATC_ACQ_DONE;
            end
            atc_pkg::ATC_TRIG: begin
                state_code = `ATC_TRIG_SEEN;
            end
            default: begin
                state_code = `ATC_ARMED_WAIT;
            end
        endcase
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (idx == `ATC_IDX_CMD) begin
            rd_val = s.cmd;
        end else if (idx == `ATC_IDX_STATE) begin
            rd_val = state_code;
        end else if (idx == `ATC_IDX_LEN) begin
            rd_val = s.len;
        end else if (idx == `ATC_IDX_POST) begin
            rd_val = s.post;
        end else if (idx == `ATC_IDX_CHAN) begin
            rd_val = {31'h0000_0000, s.two_ch};
        end else if (idx == `ATC_IDX_SETTLE) begin
            rd_val = s.settle;
        end else if (idx == `ATC_IDX_DIV) begin
            rd_val = {16'h0000, s.div};
        end else if (idx == `ATC_IDX_IRQ_STS) begin
            rd_val = {30'h0000_0000, s.irq_sts};
        end else if (idx == `ATC_IDX_IRQ_MASK) begin
            rd_val = {30'h0000_0000, s.irq_mask};
        end else begin
            rd_err = 1'b1;
        end
    end

    always_comb begin
        next_s = s;
        events = 2'b00;
        next_s.mem_we = 1'b0;

        // Two-flop synchroniser, then an edge detector on the second stage
        next_s.trig_m = trig_in;
        next_s.trig_s = s.trig_m;
        next_s.trig_d = s.trig_s;

        // Registered answer: pready rises in the first access cycle
        next_s.pready = setup_ph;
        next_s.pslverr = 1'b0;
        if (setup_ph) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd_val;
            next_s.pslverr = rd_err;
        end

        // Sample-rate divider: one tick every div+1 clocks while recording
        if (s.st == atc_pkg::ATC_IDLE || s.st == atc_pkg::ATC_SETTLE) begin
            next_s.div_cnt = s.div;
        end else if (s.div_cnt == 16'h0000) begin
            next_s.div_cnt = s.div;
        end else begin
            next_s.div_cnt = s.div_cnt - 16'h0001;
        end

        case (s.st)
            atc_pkg::ATC_IDLE: begin
            end
            atc_pkg::ATC_SETTLE: begin
                if (s.cnt == 32'h0000_0000) begin
                    next_s.st = atc_pkg::ATC_PREFILL;
                    if (s.run_post > s.run_len) begin
                        next_s.cnt = 32'h0000_0000;
                    end else begin
                        next_s.cnt = s.run_len - s.run_post;
                    end
                end else begin
                    next_s.cnt = s.cnt - 32'h0000_0001;
                end
            end
            atc_pkg::ATC_PREFILL: begin
                if (s.cnt == 32'h0000_0000) begin
                    next_s.st = atc_pkg::ATC_ARMED;
                end else if (tick) begin
                    next_s.mem_we = 1'b1;
                    next_s.cnt = s.cnt - 32'h0000_0001;
                end
            end
            atc_pkg::ATC_ARMED: begin
                if (tick) begin
                    next_s.mem_we = 1'b1;
                end
                if (trig_rise) begin
                    next_s.st = atc_pkg::ATC_TRIG;
                    next_s.cnt = s.run_post;
                    events[`ATC_IRQ_TRIG] = 1'b1;
                end
            end
            atc_pkg::ATC_TRIG: begin
                if (s.cnt == 32'h0000_0000) begin
                    next_s.st = atc_pkg::ATC_IDLE;
                    events[`ATC_IRQ_DONE] = 1'b1;
                end else if (tick) begin
                    next_s.mem_we = 1'b1;
                    next_s.cnt = s.cnt - 32'h0000_0001;
                end
            end
            default: begin
                next_s.st = atc_pkg::ATC_IDLE;
            end
        endcase

        // Ring addressing inside the recorded region
        if (next_s.mem_we) begin
            next_s.mem_addr = s.waddr;
            if (s.waddr >= s.run_len - 32'h0000_0001) begin
                next_s.waddr = 32'h0000_0000;
            end else begin
                next_s.waddr = s.waddr + 32'h0000_0001;
            end
        end

        if (wr_ph) begin
            if (idx == `ATC_IDX_CMD) begin
                next_s.cmd = pwdata;
                if (pwdata == `ATC_LAUNCH_CODE) begin
                    next_s.st = atc_pkg::ATC_SETTLE;
                    next_s.run_len = s.len;
                    next_s.run_post = s.post;
                    next_s.cnt = s.settle;
                    next_s.waddr = 32'h0000_0000;
                end else if (pwdata == `ATC_HALT_CODE) begin
                    next_s.st = atc_pkg::ATC_IDLE;
                    next_s.mem_we = 1'b0;
                end
            end else if (idx == `ATC_IDX_LEN) begin
                next_s.len = fit(pwdata, len_max, s.two_ch);
            end else if (idx == `ATC_IDX_POST) begin
                next_s.post = fit(pwdata, post_max, s.two_ch);
            end else if (idx == `ATC_IDX_CHAN) begin
                next_s.two_ch = pwdata[0];
            end else if (idx == `ATC_IDX_SETTLE) begin
                next_s.settle = pwdata;
            end else if (idx == `ATC_IDX_DIV) begin
                next_s.div = pwdata[15:0];
            end else if (idx == `ATC_IDX_IRQ_STS) begin
                next_s.irq_sts = s.irq_sts & ~pwdata[1:0];
            end else if (idx == `ATC_IDX_IRQ_MASK) begin
                next_s.irq_mask = pwdata[1:0];
            end
        end

        // Set after clear so an event in the clearing cycle is kept
        next_s.irq_sts = next_s.irq_sts | events;
        next_s.irq = |(next_s.irq_sts & next_s.irq_mask);
        next_s.active = (next_s.st != atc_pkg::ATC_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= atc_pkg::ATC_IDLE;
            s.len <= `ATC_LEN_RST;
            s.post <= `ATC_POST_RST;
            s.settle <= `ATC_SETTLE_RST;
            s.div <= `ATC_DIV_RST;
            s.run_len <= `ATC_LEN_RST;
            s.run_post <= `ATC_POST_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign mem_we = s.mem_we;
    assign mem_addr = s.mem_addr;
    assign acq_active = s.active;
    assign irq = s.irq;

endmodule

`default_nettype wire

// ### atc_chk_sva.sv
// Port-level checker for the acquisition control.
// Assumes it is bound into atc_trigger_control; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module atc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trig_in,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic acq_active,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic st_acc = psel && penable && paddr == 18'h00028 && pready;
    wire logic st_rd = st_acc && !pwrite;
    wire logic cmd_wr = psel && penable && pwrite && paddr == 18'h00000 && pready;
    AST_READY_ONE: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_STATE_NOERR: assert property (st_acc |-> !pslverr)
        else $error("status access flagged as error");
    AST_LAUNCH: assert property (cmd_wr && pwdata == 32'h0000_000a |=> acq_active [*2])
        else $error("launch did not start the run");
    AST_HALT: assert property (cmd_wr && pwdata == 32'h0000_0014 |=> !acq_active)
        else $error("halt did not stop at once");
    AST_STORE_ACTIVE: assert property (mem_we |-> $past(acq_active))
        else $error("sample stored while stopped");
    AST_ADDR_RING: assert property (mem_we && $past(mem_we) |->
        mem_addr == $past(mem_addr) + 32'h1 || mem_addr == 32'h0)
        else $error("store address not stepping round the ring");
    AST_DONE_CODE: assert property (st_rd && !$past(acq_active) |-> prdata == 32'h14)
        else $error("stopped run not reported as stopped");
    AST_RUN_CODE: assert property (st_rd && $past(acq_active) |->
        prdata == 32'h0 || prdata == 32'ha)
        else $error("running state code wrong");
    cover property (cmd_wr && pwdata == 32'h0000_000a);
    cover property (st_rd && prdata == 32'h0000_000a);
    cover property (pslverr);
endmodule
`default_nettype wire

// ### atc_trig_src.sv
// Far-side model: trigger source and sample-memory store counter.
// Assumes fire is driven synchronously by the bench.
`timescale 1ns/100ps
`default_nettype none
module atc_trig_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic clr,
    input wire logic mem_we,
    output logic trig_in,
    output logic [31:0] stores
);
    // Trigger pin follows fire; the bench holds it long enough for the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_in <= 1'b0;
            stores <= 32'h0;
        end else begin
            trig_in <= fire;
            stores <= clr ? 32'h0 : stores + {31'h0, mem_we};
        end
    end
endmodule
`default_nettype wire

// ### atc_trigger_control_tb.sv
// Self-checking bench for the acquisition control over APB.
// Assumes atc_regs.svh and a store-counting trigger model.
`include "atc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module atc_trigger_control_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, clr = 0;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, mem_addr, stores, q, v;
    logic pready, pslverr, trig_in, mem_we, acq_active, irq, e;
    int mismatches = 0, cmp_count = 0, n;
    always #2.5 pclk = ~pclk;
    atc_trigger_control u_atc_trigger_control (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .mem_we(mem_we),
        .mem_addr(mem_addr), .acq_active(acq_active), .irq(irq));
    atc_trig_src u_atc_trig_src (.pclk(pclk), .presetn(presetn), .fire(fire), .clr(clr),
        .mem_we(mem_we), .trig_in(trig_in), .stores(stores));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin mismatches++; conclude(); end
        q = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function automatic logic [31:0] snap(logic [31:0] d, logic two, logic post);
        logic [31:0] st, mx, r;
        st = two ? `ATC_STEP_TWO : `ATC_STEP_ONE;
        mx = post ? (two ? `ATC_POST_MAX_TWO : `ATC_POST_MAX_ONE)
                  : (two ? `ATC_MEM_SAMPLES >> 1 : `ATC_MEM_SAMPLES);
        r = d & ~(st - 32'h1);
        if (r < st) r = st;
        if (r > mx) r = mx;
        return r;
    endfunction
    task automatic launch(input logic [31:0] code);
        clr <= 1; apb(1, 18'h0, code); clr <= 0;
    endtask
    task automatic pulse();
        fire <= 1; repeat (4) @(posedge pclk); fire <= 0; repeat (8) @(posedge pclk);
    endtask
    initial begin
        void'($urandom(99));
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, 18'h09c40, 0); chk(q, `ATC_LEN_RST);
        apb(0, 18'h09dd0, 0); chk(q, `ATC_POST_RST);
        apb(1, 18'h00028, 0); chk({31'h0, e}, 0);
        apb(0, 18'h00028, 0); chk(q, `ATC_ACQ_DONE);
        apb(0, 18'h3fffc, 0); chk({31'h0, e}, 1);
        apb(1, 18'h3fffc, 5); chk({31'h0, e}, 1);
        for (int ch = 0; ch < 2; ch++) begin
            apb(1, 18'h0c000, ch);
            for (int i = 0; i < 8; i++) begin
                v = i == 0 ? 0 : i == 1 ? 32'hffff_ffff : i == 2 ? 32'h17 : $urandom >> (i * 3);
                apb(1, 18'h09c40, v); apb(0, 18'h09c40, 0);
                chk(q, snap(v, ch[0], 0));
                apb(1, 18'h09dd0, v); apb(0, 18'h09dd0, 0);
                chk(q, snap(v, ch[0], 1));
            end
        end
        // Setup before launch, post below length
        apb(1, 18'h0c000, 0); apb(1, 18'h0c008, 15); apb(1, 18'h0c004, 40);
        apb(1, 18'h0c010, 3); apb(1, 18'h09c40, 64); apb(1, 18'h09dd0, 32);
        launch(`ATC_LAUNCH_CODE);
        apb(0, 18'h00028, 0); chk(q, `ATC_ARMED_WAIT);
        repeat (20) @(posedge pclk);
        chk(stores, 0);
        pulse();
        apb(0, 18'h00028, 0); chk(q, `ATC_ARMED_WAIT);
        apb(1, 18'h0, `ATC_HALT_CODE);
        apb(0, 18'h00028, 0); chk(q, `ATC_ACQ_DONE);
        chk({31'h0, irq}, 0);
        chk({31'h0, acq_active}, 0);
        launch(`ATC_LAUNCH_CODE);
        for (n = 0; n < 2000 && stores < 32; n++) @(posedge pclk);
        if (n == 2000) begin mismatches++; conclude(); end
        pulse();
        apb(0, 18'h00028, 0); chk(q, `ATC_TRIG_SEEN);
        chk({31'h0, irq}, 1);
        for (n = 0; n < 400 && q !== `ATC_ACQ_DONE; n++) apb(0, 18'h00028, 0);
        chk(q, `ATC_ACQ_DONE);
        chk({31'h0, acq_active}, 0);
        chk({31'h0, mem_addr < 32'd64}, 1);
        chk({31'h0, stores >= 32'd64}, 1);
        apb(0, 18'h0c00c, 0); chk(q, 3);
        apb(1, 18'h0c00c, 3); @(posedge pclk);
        chk({31'h0, irq}, 0);
        conclude();
    end
endmodule
bind atc_trigger_control atc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .mem_we(mem_we),
    .mem_addr(mem_addr), .acq_active(acq_active), .irq(irq));
`default_nettype wire
